// file: logic/mcsos_pkg.sv
package mcsos_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [15:0] ADDR_MAIN_CLOCK_MODE    = 16'hFFA1;
  localparam logic [15:0] ADDR_OSC_STAB_STATUS    = 16'hFFA3;
  localparam logic [15:0] ADDR_OSC_STAB_TIME_SEL  = 16'hFFA4;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          BIT_PERIPH_SOURCE_SEL   = 2;
  localparam int          BIT_MAIN_CLOCK_STATUS   = 1;
  localparam int          BIT_MAIN_SOURCE_SEL     = 0;
  localparam logic [7:0]  RESET_MAIN_CLOCK_MODE   = 8'h00;
  localparam logic [7:0]  RESET_OSC_STAB_STATUS   = 8'h00;
  localparam logic [2:0]  RESET_OSC_STAB_TIME_SEL = 3'h5;

  // ****************************************
  // Wait select codes and crystal cycle milestones
  // ****************************************
  localparam logic [2:0]  WAIT_SEL_A              = 3'h1;
  localparam logic [2:0]  WAIT_SEL_B              = 3'h2;
  localparam logic [2:0]  WAIT_SEL_C              = 3'h3;
  localparam logic [2:0]  WAIT_SEL_D              = 3'h4;
  localparam logic [2:0]  WAIT_SEL_E              = 3'h5;
  localparam int          STAB_COUNT_WIDTH        = 17;
  localparam logic [16:0] MILESTONE_A_CYCLES      = 17'h00800;
  localparam logic [16:0] MILESTONE_B_CYCLES      = 17'h02000;
  localparam logic [16:0] MILESTONE_C_CYCLES      = 17'h04000;
  localparam logic [16:0] MILESTONE_D_CYCLES      = 17'h08000;
  localparam logic [16:0] MILESTONE_E_CYCLES      = 17'h10000;
endpackage

// file: logic/mcsos_clock_ctl.sv
`timescale 1ns/1ns
// What this block does
// - Reset loads main clock mode with zeros; both clocks start internal.
// - Bit 2 clear: both internal; bit 2 only: peripheral external; both: both external.
// - Bit 1 is read-only status: 1 when main clock runs external.
// - Peripheral source bit accepts one change per reset; later writes ignored.
// - Watchdog and slow-clock timer stay on slow internal clock always.
// - Status cleared on reset, STOP execution, and crystal halt set.
// - Status bits set in thermometer order at 2^11..2^16 crystal cycles, sticky.
// - Counter stops at selected wait; only milestones up to it set.
// - Status register read-only, bits 7..5 read zero, writes ignored.
// - Wait codes 1..5 map to 2^11, 2^13, 2^14, 2^15, 2^16 cycles.
// - Wait select resets to 05H and takes byte writes only.
// - On crystal CPU clock, hold CPU after STOP release until wait elapses.
// - Counting starts only once crystal oscillation actually runs.
module mcsos_clock_ctl (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [15:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_wr_bit,
  input  wire logic [2:0] cpu_bit_index,
  input  wire logic [7:0] cpu_wdata,
  input  wire logic       cpu_rd,
  output logic      [7:0] cpu_rdata,
  input  wire logic       crystal_clock,
  input  wire logic       crystal_osc_running,
  input  wire logic       crystal_osc_halt,
  input  wire logic       stop_exec,
  input  wire logic       stop_release,
  input  wire logic       main_mux_ack,
  output logic            main_use_high_speed,
  output logic            periph_use_high_speed,
  output logic            wdt_on_slow_clock,
  output logic            cpu_hold
);
  import mcsos_pkg::*;

  logic                        main_sel;
  logic                        periph_sel;
  logic                        periph_locked;
  logic                        main_clock_status;
  logic [2:0]                  time_sel;
  logic [4:0]                  stab_status;
  logic [STAB_COUNT_WIDTH-1:0] stab_count;
  logic [2:0]                  x1_sync;
  logic [1:0]                  run_sync;
  logic [1:0]                  ack_sync;
  logic                        x1_edge;
  logic                        stab_clear;
  logic                        mode_wr;
  logic [7:0]                  mode_wdata;
  logic [STAB_COUNT_WIDTH-1:0] wait_limit;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [STAB_COUNT_WIDTH-1:0] wait_cycles(input logic [2:0] sel);
    unique case (sel)
      WAIT_SEL_A: wait_cycles = MILESTONE_A_CYCLES;
      WAIT_SEL_B: wait_cycles = MILESTONE_B_CYCLES;
      WAIT_SEL_C: wait_cycles = MILESTONE_C_CYCLES;
      WAIT_SEL_D: wait_cycles = MILESTONE_D_CYCLES;
      // Prohibited codes fall back to the longest wait
      default:    wait_cycles = MILESTONE_E_CYCLES;
    endcase
  endfunction

  function automatic logic [4:0] milestones(input logic [STAB_COUNT_WIDTH-1:0] cnt);
    milestones = {cnt >= MILESTONE_A_CYCLES, cnt >= MILESTONE_B_CYCLES, cnt >= MILESTONE_C_CYCLES,
                  cnt >= MILESTONE_D_CYCLES, cnt >= MILESTONE_E_CYCLES};
  endfunction

  assign wait_limit = wait_cycles(time_sel);
  assign x1_edge    = x1_sync[1] & ~x1_sync[2];
  assign stab_clear = stop_exec | crystal_osc_halt;
  assign mode_wr    = cpu_wr && cpu_addr == ADDR_MAIN_CLOCK_MODE;
  assign mode_wdata = cpu_wr_bit ? (8'h00 | (8'h01 << cpu_bit_index)) & cpu_wdata
                                   | ~(8'h01 << cpu_bit_index)
                                     & {5'h00, periph_sel, main_clock_status, main_sel}
                                 : cpu_wdata;

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      x1_sync  <= 3'h0;
      run_sync <= 2'h0;
      ack_sync <= 2'h0;
    end else begin
      x1_sync  <= {x1_sync[1:0], crystal_clock};
      run_sync <= {run_sync[0], crystal_osc_running};
      ack_sync <= {ack_sync[0], main_mux_ack};
    end
  end

  // ****************************************
  // Main clock mode register
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      main_sel      <= RESET_MAIN_CLOCK_MODE[BIT_MAIN_SOURCE_SEL];
      periph_sel    <= RESET_MAIN_CLOCK_MODE[BIT_PERIPH_SOURCE_SEL];
      periph_locked <= 1'b0;
    end else if (mode_wr) begin
      main_sel <= mode_wdata[BIT_MAIN_SOURCE_SEL];
      if (!periph_locked && mode_wdata[BIT_PERIPH_SOURCE_SEL] != periph_sel) begin
        periph_sel    <= mode_wdata[BIT_PERIPH_SOURCE_SEL];
        periph_locked <= 1'b1;
      end
    end
  end

  // Selects are driven from flops so the external mux sees clean levels
  always_ff @(posedge clock) begin
    if (!resetn) begin
      main_use_high_speed   <= 1'b0;
      periph_use_high_speed <= 1'b0;
      wdt_on_slow_clock     <= 1'b1;
      main_clock_status     <= 1'b0;
    end else begin
      main_use_high_speed   <= periph_sel & main_sel;
      periph_use_high_speed <= periph_sel;
      wdt_on_slow_clock     <= 1'b1;
      // Status waits for the mux, which switches only on safe clock phases
      main_clock_status     <= ack_sync[1];
    end
  end

  // ****************************************
  // Stabilization time select register
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      time_sel <= RESET_OSC_STAB_TIME_SEL;
    end else if (cpu_wr && !cpu_wr_bit && cpu_addr == ADDR_OSC_STAB_TIME_SEL) begin
      time_sel <= cpu_wdata[2:0];
    end
  end

  // ****************************************
  // Stabilization counter and status
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn || stab_clear) begin
      stab_count  <= '0;
      stab_status <= 5'h00;
    end else begin
      if (run_sync[1] && x1_edge && stab_count < wait_limit) begin
        stab_count <= stab_count + 1'b1;
      end
      stab_status <= stab_status | milestones(stab_count);
    end
  end

  // CPU hold only when the main clock really runs on the crystal
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpu_hold <= 1'b0;
    end else if (stop_release && main_clock_status) begin
      cpu_hold <= 1'b1;
    end else if (stab_count >= wait_limit) begin
      cpu_hold <= 1'b0;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      unique case (cpu_addr)
        ADDR_MAIN_CLOCK_MODE:   cpu_rdata <= {5'h00, periph_sel, main_clock_status, main_sel};
        ADDR_OSC_STAB_STATUS:   cpu_rdata <= {3'h0, stab_status};
        ADDR_OSC_STAB_TIME_SEL: cpu_rdata <= {5'h00, time_sel};
        default:                cpu_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_reset_values;
    @(posedge clock) !resetn |=> (!main_sel && !periph_sel && time_sel == 3'h5 && stab_status == 5'h00);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_decode;
    @(posedge clock) disable iff (!resetn)
      1'b1 |=> (main_use_high_speed == ($past(periph_sel) & $past(main_sel)))
               && (periph_use_high_speed == $past(periph_sel));
  endproperty
  a_decode: assert property (p_decode) else $error("clock select decode wrong");

  property p_status_follows_ack;
    @(posedge clock) disable iff (!resetn)
      $rose(main_mux_ack) ##1 main_mux_ack [*3] |-> main_clock_status;
  endproperty
  a_status_follows_ack: assert property (p_status_follows_ack) else $error("status lags mux");

  property p_status_bit_readonly;
    @(posedge clock) disable iff (!resetn)
      mode_wr && ack_sync[1] == main_clock_status |=> $stable(main_clock_status);
  endproperty
  a_status_bit_readonly: assert property (p_status_bit_readonly) else $error("status bit changed");

  property p_periph_locked;
    @(posedge clock) disable iff (!resetn) periph_locked |=> $stable(periph_sel);
  endproperty
  a_periph_locked: assert property (p_periph_locked) else $error("peripheral select changed twice");

  property p_wdt_slow;
    @(posedge clock) disable iff (!resetn) ##1 wdt_on_slow_clock;
  endproperty
  a_wdt_slow: assert property (p_wdt_slow) else $error("watchdog left slow clock");

  property p_clear_on_stop;
    @(posedge clock) disable iff (!resetn) stab_clear |=> stab_status == 5'h00 && stab_count == '0;
  endproperty
  a_clear_on_stop: assert property (p_clear_on_stop) else $error("status not cleared");

  property p_thermometer;
    @(posedge clock) disable iff (!resetn)
      !stab_clear |=> (stab_status & $past(stab_status)) == $past(stab_status)
                      && stab_status inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F};
  endproperty
  a_thermometer: assert property (p_thermometer) else $error("status not thermometer");

  property p_count_limit;
    @(posedge clock) disable iff (!resetn)
      $past(time_sel) == time_sel |-> stab_count <= wait_limit;
  endproperty
  a_count_limit: assert property (p_count_limit) else $error("counter passed wait");

  property p_status_read;
    @(posedge clock) disable iff (!resetn)
      cpu_rd && cpu_addr == ADDR_OSC_STAB_STATUS |=> cpu_rdata[7:5] == 3'h0;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status high bits set");

  property p_hold_release;
    @(posedge clock) disable iff (!resetn)
      cpu_hold && stab_count >= wait_limit && !(stop_release && main_clock_status) |=> !cpu_hold;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("cpu hold not released");

  property p_no_count_idle;
    @(posedge clock) disable iff (!resetn)
      !run_sync[1] && !stab_clear |=> $stable(stab_count);
  endproperty
  a_no_count_idle: assert property (p_no_count_idle) else $error("counted before oscillation");
endmodule

// file: dv/mcsos_tb.sv
`timescale 1ns/1ns
module testbench;
  import mcsos_pkg::*;
  // ****************************************
  // Stimulus, observed outputs and counters
  // ****************************************
  logic        clock, resetn, cpu_wr, cpu_wr_bit, cpu_rd;
  logic [15:0] cpu_addr;
  logic [2:0]  cpu_bit_index;
  logic [7:0]  cpu_wdata, cpu_rdata;
  logic        crystal_clock, crystal_osc_running, crystal_osc_halt, stop_exec, stop_release, main_mux_ack;
  logic        main_use_high_speed, periph_use_high_speed, wdt_on_slow_clock, cpu_hold, xtal_en;
  int          failures, num_checks, cycles;

  mcsos_clock_ctl dut (.clock(clock), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_wr_bit(cpu_wr_bit), .cpu_bit_index(cpu_bit_index), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .crystal_clock(crystal_clock), .crystal_osc_running(crystal_osc_running),
    .crystal_osc_halt(crystal_osc_halt), .stop_exec(stop_exec), .stop_release(stop_release),
    .main_mux_ack(main_mux_ack), .main_use_high_speed(main_use_high_speed),
    .periph_use_high_speed(periph_use_high_speed), .wdt_on_slow_clock(wdt_on_slow_clock),
    .cpu_hold(cpu_hold));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Crystal at 32 ns, slow enough for the two-flop sampler
  always #16 if (xtal_en) crystal_clock = ~crystal_clock;

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_write(input logic [15:0] a, input logic [7:0] d, input logic bw, input logic [2:0] idx);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr_bit = bw;
    cpu_bit_index = idx;
    cpu_wr = 1'b1;
    wait_cyc(1);
    cpu_wr = 1'b0;
    wait_cyc(1);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    cpu_addr = a;
    cpu_rd = 1'b1;
    wait_cyc(1);
    cpu_rd = 1'b0;
    wait_cyc(1);
    check8(what, exp, cpu_rdata);
  endtask

  task automatic pulse_stop(input logic rel);
    if (rel) stop_release = 1'b1;
    else stop_exec = 1'b1;
    wait_cyc(1);
    stop_release = 1'b0;
    stop_exec = 1'b0;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Whole run is about 75000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      $display("Error timeout expected end seen hang");
      complete_run;
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {failures, num_checks, cycles} = '0;
    {resetn, cpu_wr, cpu_wr_bit, cpu_rd, crystal_clock, crystal_osc_halt, stop_exec, stop_release} = '0;
    {main_mux_ack, xtal_en} = '0;
    crystal_osc_running = 1'b1;
    cpu_addr = 16'h0000;
    cpu_bit_index = 3'h0;
    cpu_wdata = 8'h00;
    wait_cyc(16);
    resetn = 1'b1;
    wait_cyc(2);
    rd_chk(ADDR_MAIN_CLOCK_MODE, RESET_MAIN_CLOCK_MODE, "mode reset");
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h00, "status reset");
    rd_chk(ADDR_OSC_STAB_TIME_SEL, {5'h00, RESET_OSC_STAB_TIME_SEL}, "wait select reset");
    rd_chk(16'hFFFF, 8'h00, "unmapped");
    check8("selects reset", 8'h00, {6'h00, main_use_high_speed, periph_use_high_speed});
    $display("test reset done");
    bus_write(ADDR_OSC_STAB_TIME_SEL, 8'hF9, 1'b0, 3'h0);
    rd_chk(ADDR_OSC_STAB_TIME_SEL, 8'h01, "wait select upper bits");
    bus_write(ADDR_OSC_STAB_TIME_SEL, 8'h02, 1'b1, 3'h1);
    rd_chk(ADDR_OSC_STAB_TIME_SEL, 8'h01, "wait select bit write");
    bus_write(ADDR_OSC_STAB_STATUS, 8'hFF, 1'b0, 3'h0);
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h00, "status write");
    $display("test registers done");
    bus_write(ADDR_MAIN_CLOCK_MODE, 8'h04, 1'b0, 3'h0);
    check8("periph only", 8'h01, {6'h00, main_use_high_speed, periph_use_high_speed});
    bus_write(ADDR_MAIN_CLOCK_MODE, 8'h01, 1'b1, 3'h0);
    check8("both fast", 8'h03, {6'h00, main_use_high_speed, periph_use_high_speed});
    bus_write(ADDR_MAIN_CLOCK_MODE, 8'h01, 1'b0, 3'h0);
    check8("periph locked", 8'h03, {6'h00, main_use_high_speed, periph_use_high_speed});
    rd_chk(ADDR_MAIN_CLOCK_MODE, 8'h05, "status before ack");
    main_mux_ack = 1'b1;
    wait_cyc(6);
    // Fast internal oscillator may stop from here on
    rd_chk(ADDR_MAIN_CLOCK_MODE, 8'h07, "status after ack");
    bus_write(ADDR_MAIN_CLOCK_MODE, 8'hF9, 1'b0, 3'h0);
    rd_chk(ADDR_MAIN_CLOCK_MODE, 8'h07, "mode upper bits");
    check8("slow clock kept", 8'h01, {7'h00, wdt_on_slow_clock});
    $display("test mode done");
    xtal_en = 1'b1;
    pulse_stop(1'b0);
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h00, "status after stop");
    pulse_stop(1'b1);
    wait_cyc(2);
    check8("hold raised", 8'h01, {7'h00, cpu_hold});
    wait_cyc(8000);
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h00, "before first milestone");
    check8("hold kept", 8'h01, {7'h00, cpu_hold});
    wait_cyc(400);
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h10, "first milestone");
    check8("hold released", 8'h00, {7'h00, cpu_hold});
    wait_cyc(25000);
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h10, "saturated at select");
    $display("test short wait done");
    bus_write(ADDR_OSC_STAB_TIME_SEL, {5'h00, WAIT_SEL_B}, 1'b0, 3'h0);
    pulse_stop(1'b0);
    wait_cyc(8400);
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h10, "second select partial");
    wait_cyc(24600);
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h18, "second select full");
    // Back on internal clock first; crystal halt only once status reads 0
    bus_write(ADDR_MAIN_CLOCK_MODE, 8'h00, 1'b1, 3'h0);
    check8("main back internal", 8'h01, {6'h00, main_use_high_speed, periph_use_high_speed});
    main_mux_ack = 1'b0;
    wait_cyc(4);
    rd_chk(ADDR_MAIN_CLOCK_MODE, 8'h04, "status back to 0");
    crystal_osc_halt = 1'b1;
    wait_cyc(1);
    crystal_osc_halt = 1'b0;
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h00, "cleared by halt");
    $display("test long wait done");
    crystal_osc_running = 1'b0;
    bus_write(ADDR_OSC_STAB_TIME_SEL, {5'h00, WAIT_SEL_A}, 1'b0, 3'h0);
    pulse_stop(1'b0);
    pulse_stop(1'b1);
    wait_cyc(2);
    check8("no hold on internal", 8'h00, {7'h00, cpu_hold});
    wait_cyc(8400);
    rd_chk(ADDR_OSC_STAB_STATUS, 8'h00, "no count before start");
    $display("test start delay done");
    complete_run;
  end
endmodule
